/* inc/mode_select_cfg.svh */
// Constants for the rate select and block programming register bank
// Function
// R1: Group 2 rate field, bits 7-6 of the mode register, picks 8, 4 or 2 Mbps for streams 8-11.
// R2: Group 1 rate field, bits 4-3, picks the rate for streams 4-7 with the same code.
// R3: Group 0 rate field, bits 1-0, picks the rate for streams 0-3 with the same code.
// R4: Software writes zero to all reserved bits of both registers.
// R5: Programming fills every backplane memory word with the backplane preset on top, zeros below.
// R6: Programming fills every local memory word with the local preset on top, zeros below.
// R7: Programming starts only on a rising enable bit while the gate bit is high.
// R8: Software writes the enable bit and both presets in one write.
// R9: Programming of both memories ends within two frames of the enable bit being set.
// R10: The device clears the enable bit itself when programming ends.
// R11: Clearing the enable bit or the gate bit while running aborts programming.
// R12: While running, software keeps the other bits unchanged and repeats them when setting enable.
// R13: An abort stops writing at once, keeps written words and drops the enable bit.
`ifndef MODE_SELECT_CFG_SVH
`define MODE_SELECT_CFG_SVH
`define ADDR_W         16
`define REG_W          16
`define MODE_REG_ADDR  16'h0001
`define PROG_REG_ADDR  16'h0002
`define GATE_ADDR      16'h0010
`define IRQ_STAT_ADDR  16'h0011
`define IRQ_CLR_ADDR   16'h0012
`define IRQ_EN_ADDR    16'h0013
`define G2_LSB         6
`define G1_LSB         3
`define G0_LSB         0
`define RATE_W         2
`define BP_PRESET_LSB  6
`define LP_PRESET_LSB  3
`define PRESET_W       3
`define PROG_EN_BIT    2
`define GATE_BIT       0
`define CM_ZERO_W      13
`define BP_CM_DEPTH    2048
`define BP_CM_AW       11
`define LP_CM_DEPTH    1024
`define LP_CM_AW       10
`define IRQ_W          2
`define IRQ_DONE       0
`define IRQ_ABORT      1
`define CLK_NS         40
`define FRAME_NS       125000
`define PROG_FRAMES    2
`define PROG_LIMIT     ((`PROG_FRAMES * `FRAME_NS) / `CLK_NS)
`define CNT_W          13
`endif

/* inc/mode_select_pkg.sv */
// Types for the rate select and block programming register bank
package mode_select_pkg;
  typedef enum logic [1:0] {
    RATE_8M   = 2'h0,
    RATE_4M   = 2'h1,
    RATE_2M   = 2'h2,
    RATE_RSVD = 2'h3
  } rate_type;
  typedef enum logic {PROG_IDLE, PROG_RUN} prog_state_type;
endpackage

/* hw/cm_sweep.sv */
// Address sweep writing one connection memory word per clock
`timescale 1ns/1ns
module cm_sweep #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic          abort,
  output logic               wr_en,
  output logic [AW-1:0]      addr,
  output logic               done
);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic          active_reg;
  logic          active_next;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] addr_next;
  logic          done_reg;
  logic          done_next;

  always_comb begin
    active_next = active_reg;
    addr_next   = addr_reg;
    done_next   = 1'b0;
    if (abort) begin
      active_next = 1'b0;
    end else if (start) begin
      active_next = 1'b1;
      addr_next   = '0;
    end else if (active_reg) begin
      if (addr_reg == LAST) begin
        active_next = 1'b0;
        done_next   = 1'b1;
      end else begin
        addr_next = addr_reg + AW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
      addr_reg   <= '0;
      done_reg   <= 1'b0;
    end else begin
      active_reg <= active_next;
      addr_reg   <= addr_next;
      done_reg   <= done_next;
    end
  end

  assign wr_en = active_reg;
  assign addr  = addr_reg;
  assign done  = done_reg;
endmodule // cm_sweep

/* hw/mode_select_block_program.sv */
// Rate select and connection memory block programming register bank
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "mode_select_cfg.svh"
module mode_select_block_program
  import mode_select_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`REG_W-1:0]      wr_data,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic [`REG_W-1:0]           rd_data,
  output rate_type                    group2_rate_sel,
  output rate_type                    group1_rate_sel,
  output rate_type                    group0_rate_sel,
  output logic                        bp_cm_wr_en,
  output logic [`BP_CM_AW-1:0]        bp_cm_addr,
  output logic [`REG_W-1:0]           bp_cm_wr_data,
  output logic                        lp_cm_wr_en,
  output logic [`LP_CM_AW-1:0]        lp_cm_addr,
  output logic [`REG_W-1:0]           lp_cm_wr_data,
  output logic                        irq
);

  function automatic rate_type rate_field(input logic [`REG_W-1:0] v, input int lsb);
    rate_field = rate_type'(v[lsb +: `RATE_W]);
  endfunction

  function automatic logic [`REG_W-1:0] cm_word(input logic [`PRESET_W-1:0] p);
    cm_word = {p, `CM_ZERO_W'(0)};
  endfunction

  // Register strobes
  logic wr_mode;
  logic wr_prog;
  logic wr_gate;
  logic wr_clr;
  logic wr_en_reg_w;
  assign wr_mode     = wr_stb && (addr == `MODE_REG_ADDR);
  assign wr_prog     = wr_stb && (addr == `PROG_REG_ADDR);
  assign wr_gate     = wr_stb && (addr == `GATE_ADDR);
  assign wr_clr      = wr_stb && (addr == `IRQ_CLR_ADDR);
  assign wr_en_reg_w = wr_stb && (addr == `IRQ_EN_ADDR);

  // Rate selection
  rate_type g2_reg, g2_next;
  rate_type g1_reg, g1_next;
  rate_type g0_reg, g0_next;

  always_comb begin
    g2_next = g2_reg;
    g1_next = g1_reg;
    g0_next = g0_reg;
    if (wr_mode) begin
      g2_next = rate_field(wr_data, `G2_LSB); // [R1]
      g1_next = rate_field(wr_data, `G1_LSB); // [R2]
      g0_next = rate_field(wr_data, `G0_LSB); // [R3]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      g2_reg <= RATE_8M;
      g1_reg <= RATE_8M;
      g0_reg <= RATE_8M;
    end else begin
      g2_reg <= g2_next;
      g1_reg <= g1_next;
      g0_reg <= g0_next;
    end
  end

  // Block programming control
  prog_state_type               state_reg, state_next;
  logic [`PRESET_W-1:0]         bp_preset_reg, bp_preset_next;
  logic [`PRESET_W-1:0]         lp_preset_reg, lp_preset_next;
  logic                         gate_reg, gate_next;
  logic [`REG_W-1:0]            bp_word_reg, bp_word_next;
  logic [`REG_W-1:0]            lp_word_reg, lp_word_next;
  logic                         start;
  logic                         abort;
  logic                         bp_done;
  logic                         lp_done;
  logic                         lp_fin_reg, lp_fin_next;
  logic                         finish;

  // Rising enable while gated and idle; presets taken from the same write
  assign start = wr_prog && wr_data[`PROG_EN_BIT] && gate_reg && // [R7] [R8]
                 (state_reg == PROG_IDLE);
  assign abort = (state_reg == PROG_RUN) && // [R11]
                 ((wr_prog && !wr_data[`PROG_EN_BIT]) ||
                  (wr_gate && !wr_data[`GATE_BIT]));
  assign finish = (state_reg == PROG_RUN) && bp_done && (lp_fin_reg || lp_done);

  always_comb begin
    state_next     = state_reg;
    bp_preset_next = bp_preset_reg;
    lp_preset_next = lp_preset_reg;
    gate_next      = gate_reg;
    bp_word_next   = bp_word_reg;
    lp_word_next   = lp_word_reg;
    lp_fin_next    = lp_fin_reg;
    if (wr_gate) begin
      gate_next = wr_data[`GATE_BIT];
    end
    // Presets are frozen while a run is under way
    if (wr_prog && state_reg == PROG_IDLE) begin
      bp_preset_next = wr_data[`BP_PRESET_LSB +: `PRESET_W];
      lp_preset_next = wr_data[`LP_PRESET_LSB +: `PRESET_W];
    end
    unique case (state_reg)
      PROG_IDLE: begin
        if (start) begin
          state_next   = PROG_RUN;
          lp_fin_next  = 1'b0;
          bp_word_next = cm_word(wr_data[`BP_PRESET_LSB +: `PRESET_W]); // [R5]
          lp_word_next = cm_word(wr_data[`LP_PRESET_LSB +: `PRESET_W]); // [R6]
        end
      end
      PROG_RUN: begin
        if (lp_done) begin
          lp_fin_next = 1'b1;
        end
        if (abort || finish) begin
          state_next = PROG_IDLE; // [R10] [R13]
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= PROG_IDLE;
      bp_preset_reg <= '0;
      lp_preset_reg <= '0;
      gate_reg      <= 1'b0;
      bp_word_reg   <= '0;
      lp_word_reg   <= '0;
      lp_fin_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bp_preset_reg <= bp_preset_next;
      lp_preset_reg <= lp_preset_next;
      gate_reg      <= gate_next;
      bp_word_reg   <= bp_word_next;
      lp_word_reg   <= lp_word_next;
      lp_fin_reg    <= lp_fin_next;
    end
  end

  // Both memories swept in parallel, one word per clock each
  cm_sweep #(.DEPTH(`BP_CM_DEPTH), .AW(`BP_CM_AW)) bp_sweep (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (start),
    .abort   (abort),
    .wr_en   (bp_cm_wr_en),
    .addr    (bp_cm_addr),
    .done    (bp_done)
  ); // [R5] [R9] [R13]

  cm_sweep #(.DEPTH(`LP_CM_DEPTH), .AW(`LP_CM_AW)) lp_sweep (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (start),
    .abort   (abort),
    .wr_en   (lp_cm_wr_en),
    .addr    (lp_cm_addr),
    .done    (lp_done)
  ); // [R6] [R9] [R13]

  // Interrupt status, enable, and read port
  logic [`IRQ_W-1:0]  stat_reg, stat_next;
  logic [`IRQ_W-1:0]  ien_reg, ien_next;
  logic [`IRQ_W-1:0]  events;
  logic               irq_reg, irq_next;
  logic [`REG_W-1:0]  rd_reg, rd_next;
  logic [`REG_W-1:0]  prog_view;

  always_comb begin
    events = '0;
    events[`IRQ_DONE]  = finish;
    events[`IRQ_ABORT] = abort;
    ien_next = ien_reg;
    if (wr_en_reg_w) begin
      ien_next = wr_data[`IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    stat_next = stat_reg;
    if (wr_clr) begin
      stat_next = stat_reg & ~wr_data[`IRQ_W-1:0];
    end
    stat_next = stat_next | events;
    irq_next  = |(stat_next & ien_next);
  end

  always_comb begin
    prog_view = '0;
    prog_view[`BP_PRESET_LSB +: `PRESET_W] = bp_preset_reg;
    prog_view[`LP_PRESET_LSB +: `PRESET_W] = lp_preset_reg;
    prog_view[`PROG_EN_BIT] = (state_reg == PROG_RUN);
    rd_next = '0;
    if (rd_stb) begin
      unique case (addr)
        `MODE_REG_ADDR: begin
          rd_next[`G2_LSB +: `RATE_W] = g2_reg;
          rd_next[`G1_LSB +: `RATE_W] = g1_reg;
          rd_next[`G0_LSB +: `RATE_W] = g0_reg;
        end
        `PROG_REG_ADDR: rd_next = prog_view;
        `GATE_ADDR:     rd_next[`GATE_BIT] = gate_reg;
        `IRQ_STAT_ADDR: rd_next[`IRQ_W-1:0] = stat_reg;
        `IRQ_EN_ADDR:   rd_next[`IRQ_W-1:0] = ien_reg;
        default:        rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= '0;
      ien_reg  <= '0;
      irq_reg  <= 1'b0;
      rd_reg   <= '0;
    end else begin
      stat_reg <= stat_next;
      ien_reg  <= ien_next;
      irq_reg  <= irq_next;
      rd_reg   <= rd_next;
    end
  end

  assign rd_data         = rd_reg;
  assign irq             = irq_reg;
  assign group2_rate_sel = g2_reg;
  assign group1_rate_sel = g1_reg;
  assign group0_rate_sel = g0_reg;
  assign bp_cm_wr_data   = bp_word_reg;
  assign lp_cm_wr_data   = lp_word_reg;

  // Checks
  logic [`CNT_W-1:0] run_cnt_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_cnt_reg <= '0;
    end else if (state_reg == PROG_RUN) begin
      run_cnt_reg <= run_cnt_reg + `CNT_W'(1);
    end else begin
      run_cnt_reg <= '0;
    end
  end

  sequence seq_start;
    wr_prog && wr_data[`PROG_EN_BIT] && gate_reg && (state_reg == PROG_IDLE);
  endsequence

  sequence seq_abort;
    (state_reg == PROG_RUN) && wr_stb &&
      (((addr == `PROG_REG_ADDR) && !wr_data[`PROG_EN_BIT]) ||
       ((addr == `GATE_ADDR) && !wr_data[`GATE_BIT]));
  endsequence

  chk_group2_rate: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    wr_mode |=> group2_rate_sel == rate_type'($past(wr_data[`G2_LSB +: `RATE_W])))
    else $error("group 2 rate not taken from write");
  chk_group1_rate: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    wr_mode |=> group1_rate_sel == rate_type'($past(wr_data[`G1_LSB +: `RATE_W])))
    else $error("group 1 rate not taken from write");
  chk_group0_rate: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    wr_mode |=> group0_rate_sel == rate_type'($past(wr_data[`G0_LSB +: `RATE_W])))
    else $error("group 0 rate not taken from write");
  chk_bp_word_form: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    bp_cm_wr_en |-> bp_cm_wr_data == {bp_preset_reg, `CM_ZERO_W'(0)})
    else $error("backplane word not preset over zeros");
  chk_lp_word_form: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
    lp_cm_wr_en |-> lp_cm_wr_data == {lp_preset_reg, `CM_ZERO_W'(0)})
    else $error("local word not preset over zeros");
  chk_bp_addr_step: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    bp_cm_wr_en && $past(bp_cm_wr_en) |-> bp_cm_addr == $past(bp_cm_addr) + `BP_CM_AW'(1))
    else $error("backplane sweep skipped a word");
  chk_lp_addr_step: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
    lp_cm_wr_en && $past(lp_cm_wr_en) |-> lp_cm_addr == $past(lp_cm_addr) + `LP_CM_AW'(1))
    else $error("local sweep skipped a word");
  chk_presets_frozen: assert property (@(posedge ref_clk) disable iff (rst) // [R5] [R6]
    state_reg == PROG_RUN |=> $stable(bp_preset_reg) && $stable(lp_preset_reg))
    else $error("preset changed during programming");
  chk_read_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rd_stb) |-> rd_data == '0)
    else $error("read data stood past its cycle");
  chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq == |(stat_reg & ien_reg))
    else $error("interrupt level not status and enable");
  chk_start_edge: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    seq_start |=> bp_cm_wr_en && lp_cm_wr_en && bp_cm_addr == '0 && lp_cm_addr == '0)
    else $error("programming did not start");
  chk_no_ungated: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    (!gate_reg && state_reg == PROG_IDLE) |=> state_reg == PROG_IDLE)
    else $error("programming started without gate");
  chk_two_frames: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
    run_cnt_reg < `CNT_W'(`PROG_LIMIT))
    else $error("programming exceeded two frames");
  chk_self_clear: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    seq_start ##1 (!abort) [*8] |-> state_reg == PROG_RUN)
    else $error("enable dropped early");
  chk_finish_clear: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    $fell(bp_cm_wr_en) && !$past(abort) |=> state_reg == PROG_IDLE && stat_reg[`IRQ_DONE])
    else $error("enable not cleared at finish");
  chk_abort_stop: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    seq_abort |=> !bp_cm_wr_en && !lp_cm_wr_en && state_reg == PROG_IDLE && stat_reg[`IRQ_ABORT])
    else $error("abort did not stop programming");
endmodule // mode_select_block_program

/* sim/mode_select_block_program_tb.sv */
// Self-checking bench for the rate select and block programming register bank
`timescale 1ns/1ns
`include "mode_select_cfg.svh"
module mode_select_block_program_tb
  import mode_select_pkg::*;
;
  logic                 ref_clk;
  logic                 rst;
  logic [`ADDR_W-1:0]   addr;
  logic [`REG_W-1:0]    wr_data;
  logic                 wr_stb;
  logic                 rd_stb;
  logic [`REG_W-1:0]    rd_data;
  rate_type             group2_rate_sel;
  rate_type             group1_rate_sel;
  rate_type             group0_rate_sel;
  logic                 bp_cm_wr_en;
  logic [`BP_CM_AW-1:0] bp_cm_addr;
  logic [`REG_W-1:0]    bp_cm_wr_data;
  logic                 lp_cm_wr_en;
  logic [`LP_CM_AW-1:0] lp_cm_addr;
  logic [`REG_W-1:0]    lp_cm_wr_data;
  logic                 irq;
  int                   errors;
  int                   n_compared;
  int                   cycles;
  int                   bp_n;
  int                   lp_n;
  logic [15:0]          bp_exp;
  logic [15:0]          lp_exp;

  mode_select_block_program u_dut (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .group2_rate_sel(group2_rate_sel),
    .group1_rate_sel(group1_rate_sel), .group0_rate_sel(group0_rate_sel),
    .bp_cm_wr_en(bp_cm_wr_en), .bp_cm_addr(bp_cm_addr), .bp_cm_wr_data(bp_cm_wr_data),
    .lp_cm_wr_en(lp_cm_wr_en), .lp_cm_addr(lp_cm_addr), .lp_cm_wr_data(lp_cm_wr_data),
    .irq(irq)
  );

  initial begin
    ref_clk = 1'h0;
    forever #(`CLK_NS/2) ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'h1;
    @(posedge ref_clk);
    wr_stb  <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge ref_clk);
    rd_stb <= 1'h0;
    @(posedge ref_clk);
    d = rd_data;
  endtask

  task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask

  task automatic chk_wr_en(input logic exp);
    @(negedge ref_clk);
    chk("bp wr_en", {15'h0, exp}, {15'h0, bp_cm_wr_en});
    chk("lp wr_en", {15'h0, exp}, {15'h0, lp_cm_wr_en});
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge ref_clk);
    chk("irq", {15'h0, exp}, {15'h0, irq});
  endtask

  task automatic start_run(input logic [15:0] d);
    bp_n   = 0;
    lp_n   = 0;
    bp_exp = {d[8:6], 13'h0};
    lp_exp = {d[5:3], 13'h0};
    wr(`PROG_REG_ADDR, d);
    chk_wr_en(1'h1);
  endtask

  // Every memory write must follow the sweep order and carry the preset word
  always @(posedge ref_clk) begin
    if (bp_cm_wr_en === 1'h1) begin
      chk("bp addr", bp_n[15:0], {5'h0, bp_cm_addr});
      chk("bp data", bp_exp, bp_cm_wr_data);
      bp_n++;
    end
    if (lp_cm_wr_en === 1'h1) begin
      chk("lp addr", lp_n[15:0], {6'h0, lp_cm_addr});
      chk("lp data", lp_exp, lp_cm_wr_data);
      lp_n++;
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    logic [15:0] v;
    logic [1:0]  g2;
    logic [1:0]  g1;
    logic [1:0]  g0;
    int          t0;
    int          n;
    rst = 1'h1;
    addr = 16'h0;
    wr_data = 16'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    bp_n = 0;
    lp_n = 0;
    bp_exp = 16'h0;
    lp_exp = 16'h0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk("rates after reset", 16'h0, {10'h0, group2_rate_sel, group1_rate_sel, group0_rate_sel});
    rdc("mode reg reset", `MODE_REG_ADDR, 16'h0);
    rdc("program reg reset", `PROG_REG_ADDR, 16'h0);
    rdc("unmapped read", 16'h0003, 16'h0);
    for (int c = 0; c < 4; c++) begin
      g2 = 2'(c);
      g1 = 2'(c + 1);
      g0 = 2'(c + 2);
      v = {8'h0, g2, 1'h0, g1, 1'h0, g0};
      wr(`MODE_REG_ADDR, v);
      @(negedge ref_clk);
      chk("group2 rate", {14'h0, g2}, {14'h0, group2_rate_sel});
      chk("group1 rate", {14'h0, g1}, {14'h0, group1_rate_sel});
      chk("group0 rate", {14'h0, g0}, {14'h0, group0_rate_sel});
      rdc("mode reg", `MODE_REG_ADDR, v);
    end
    $display("test rate select ended");
    wr(`GATE_ADDR, 16'h0);
    wr(`PROG_REG_ADDR, 16'h015C);
    chk_wr_en(1'h0);
    rd(`PROG_REG_ADDR, v);
    chk("enable without gate", 16'h0, {15'h0, v[2]});
    chk("no writes without gate", 16'h0, bp_n[15:0]);
    $display("test gate closed ended");
    wr(`IRQ_EN_ADDR, 16'h0003);
    wr(`GATE_ADDR, 16'h0001);
    t0 = cycles;
    start_run(16'h015C);
    wr(`PROG_REG_ADDR, 16'h015C);
    do begin
      rd(`PROG_REG_ADDR, v);
    end while (v[2] === 1'h1 && cycles - t0 < 8000);
    chk("within two frames", 16'h1, {15'h0, cycles - t0 <= `PROG_LIMIT});
    chk("enable self clear", 16'h0158, v);
    chk("bp word count", 16'h0800, bp_n[15:0]);
    chk("lp word count", 16'h0400, lp_n[15:0]);
    rdc("done status", `IRQ_STAT_ADDR, 16'h0001);
    chk_irq(1'h1);
    wr(`IRQ_CLR_ADDR, 16'h0001);
    chk_irq(1'h0);
    rdc("status cleared", `IRQ_STAT_ADDR, 16'h0);
    $display("test full run ended");
    wr(`IRQ_EN_ADDR, 16'h0);
    for (int k = 0; k < 2; k++) begin
      start_run(16'h0084);
      repeat (20) @(posedge ref_clk);
      if (k == 0) begin
        wr(`PROG_REG_ADDR, 16'h0080);
      end else begin
        wr(`GATE_ADDR, 16'h0);
      end
      chk_wr_en(1'h0);
      n = bp_n;
      repeat (10) @(posedge ref_clk);
      chk("writes stop", n[15:0], bp_n[15:0]);
      rd(`PROG_REG_ADDR, v);
      chk("enable after abort", 16'h0, {15'h0, v[2]});
      rdc("abort status", `IRQ_STAT_ADDR, 16'h0002);
      chk_irq(1'h0);
      wr(`IRQ_EN_ADDR, 16'h0002);
      chk_irq(1'h1);
      wr(`IRQ_CLR_ADDR, 16'h0002);
      chk_irq(1'h0);
      wr(`IRQ_EN_ADDR, 16'h0);
      wr(`GATE_ADDR, 16'h0001);
    end
    $display("test abort ended");
    test_done();
  end
endmodule // mode_select_block_program_tb
